// >>> pkg/msc_pkg.sv
// Purpose: Shared constants and types of the motor starter control sequencer.
// Assumes: One 40 MHz control clock; all times are counted in 1 ms ticks.
// Notes: Current in 10 mA units, voltage in percent, current ratios in 1/32 units.
package msc_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int MS_PER_S = 1000;
   localparam int MS_CYC = CLK_HZ / MS_PER_S;
   localparam logic [11:0] IE_MIN = 12'h00f;
   localparam logic [11:0] IE_MAX = 12'h4b0;
   localparam logic [11:0] IE_DIRECT = 12'h384;
   localparam logic [15:0] V_STEP_PCT = 16'h0005;
   localparam logic [15:0] V_MIN_PCT = 16'h0014;
   localparam logic [15:0] VSTOP_MAX_PCT = 16'h005a;
   localparam logic [6:0] V_FULL_PCT = 7'h64;
   localparam logic [6:0] V_DEF_PCT = 7'h28;
   localparam logic [15:0] T_MAX_Q = 16'h0078;
   localparam logic [15:0] T_Q_MS = 16'h00fa;
   localparam logic [15:0] START_MIN_MS = 16'h0064;
   localparam logic [15:0] SETTLE_MS = 16'h0050;
   localparam logic [15:0] LOCK_ZERO_MS = 16'h0096;
   localparam logic [15:0] LOCK_MAX_S = 16'h003c;
   localparam logic [15:0] ILIM_MIN = 16'h0028;
   localparam logic [15:0] ILIM_MAX = 16'h00c0;
   localparam logic [15:0] ILIM_MAX_HI = 16'h00b0;
   localparam logic [3:0] CLASS_5 = 4'h5;
   localparam logic [3:0] CLASS_10 = 4'ha;
   localparam int IMG_W = 9;
   localparam int IMG_FWD = 0;
   localparam int IMG_REV = 1;
   localparam int IMG_BRAKE = 2;
   localparam int IMG_TRIP_RST = 3;
   localparam int IMG_EMSTART = 4;
   localparam int IMG_SELFTEST = 5;
   localparam int IMG_OUT1 = 6;
   localparam int IMG_OUT2 = 7;
   localparam int IMG_QSTOP_DIS = 8;
   localparam logic [IMG_W-1:0] SUBST_RST = 9'h000;
   typedef enum logic [1:0] {SM_DIRECT = 2'b00, SM_RAMP = 2'b01, SM_ILIM = 2'b10,
      SM_RAMP_ILIM = 2'b11} startup_e;
   typedef enum logic [1:0] {SR_FAULT = 2'b00, SR_FAULT_ON = 2'b01, SR_WARN = 2'b10,
      SR_SPARE = 2'b11} supply_resp_e;
   typedef enum logic [1:0] {D_IDLE = 2'b00, D_SETTLE = 2'b01, D_RUN = 2'b10,
      D_LOCK = 2'b11} dir_state_e;
   typedef enum logic [1:0] {V_OFF = 2'b00, V_UP = 2'b01, V_ON = 2'b10,
      V_DOWN = 2'b11} volt_state_e;
endpackage : msc_pkg

// >>> hdl/motor_starter_control_sequencer.sv
// Purpose: Control sequencer of a fieldbus motor starter.
// Assumes: All inputs synchronous to CLK; CFG_LOAD pulses to take a new parameter set.
// Notes: Protection, fail-safe image, reversing interlock, soft start/stop, brake.
// Contract
// - Rated current 0.15 to 12 A, preset maximum.
// - Direct start limits rated current to 9 A.
// - Asymmetry detection off for single-phase load.
// - Overload retained over supply loss if set.
// - Switch supply loss gives fault, on-fault, warning.
// - Master STOP in automatic: hold or substitute.
// - Bus failure drives outputs from substitute image; the code does so only with STOP_SUBST set, else holds the last value.
// - Substitute image has one bit per command.
// - Reject substitute image with both directions set.
// - Group diagnostics block suppresses error messages.
// - Never energise both rotation directions together.
// - Contactor resets forward; a direction change waits 80 ms.
// - Lock-out 0 to 60 s; zero means 150 ms.
// - Lock-out flagged; opposite direction ON suppressed.
// - Regenerative run-down aborts ramp, motor off.
// - Zero holding time: brake off with motor.
// - Holding timer runs parallel, brake off at expiry.
// - Start ramp linear; zero start gives 100 ms.
// - Run-down ramp to stop voltage; zero switches off.
// - Four startup modes; ramp abandoned above limit.
// - Direct start: 9 A and classes 5, 10.
// - Run-down without load or voltage ramp.
// - Voltages 5 % steps, default 40; times 0.25 s.
// - Current limit 125 to 600 or 550 %.
`timescale 1ns/1ps
`default_nettype none
module motor_starter_control_sequencer #(
   parameter int MS_CYC_P = msc_pkg::MS_CYC,
   parameter logic [11:0] IE_MAX_P = msc_pkg::IE_MAX
) (
   input wire logic CLK, // 40 MHz control clock
   input wire logic RESET_N, // asynchronous reset, active low
   input wire logic CFG_LOAD, // pulse: take parameter inputs
   input wire logic [11:0] IE_SET, // rated current, 10 mA units
   input wire msc_pkg::startup_e STARTUP_MODE, // startup mode
   input wire logic [3:0] TRIP_CLASS, // overload trip class
   input wire logic [4:0] V_START_STEP, // starting voltage, 5 % steps
   input wire logic [4:0] V_STOP_STEP, // stopping voltage, 5 % steps
   input wire logic [6:0] START_T, // start time, 0.25 s units
   input wire logic [6:0] RUNDOWN_T, // run-down time, 0.25 s units
   input wire logic RUNDOWN_RAMP, // run-down type: 1 ramp, 0 without load
   input wire logic [7:0] ILIM_SET, // current limit, 1/32 of rated
   input wire logic [5:0] LOCKOUT_S, // lock-out time in seconds
   input wire logic [15:0] BRAKE_HOLD_MS, // brake holding time in ms
   input wire logic LOAD_1PH, // load type single-phase
   input wire logic VFAIL_RETAIN, // keep overload over supply loss
   input wire msc_pkg::supply_resp_e SUPPLY_RESP, // switch supply loss response
   input wire logic STOP_SUBST, // 1 substitute, 0 hold last value
   input wire logic [msc_pkg::IMG_W-1:0] SUBST_IMG, // substitute image
   input wire logic GRP_DIAG_EN, // group diagnostics enable
   input wire logic AUTO_MODE, // automatic mode
   input wire logic MASTER_STOP, // master in STOP
   input wire logic BUS_FAIL, // fieldbus failure
   input wire logic [msc_pkg::IMG_W-1:0] CMD_IMG, // live command image
   input wire logic [7:0] CUR_RATIO, // motor current, 1/32 of rated
   input wire logic REGEN, // load drives the motor
   input wire logic ASYM_RAW, // phase currents unbalanced
   input wire logic OVERLOAD_EV, // overload trip event
   input wire logic ELEC_SUPPLY_OK, // electronics supply present
   input wire logic SW_SUPPLY_OK, // switching element supply present
   output logic [11:0] IE_EFF, // effective rated current
   output logic [7:0] ILIM_EFF, // effective current limit
   output logic PARAM_REJ, // last parameter set rejected
   output logic [msc_pkg::IMG_W-1:0] EFF_IMG, // image in force
   output logic ASYM_EN, // asymmetry detection enabled
   output logic ASYM_FLT, // asymmetry fault
   output logic OVL_PEND, // overload pending
   output logic GRP_FAULT, // group fault
   output logic GRP_WARN, // group warning
   output logic DIAG_TX, // error message sent on fieldbus
   output logic CONT_REV, // reversing contactor energised
   output logic SW_ON, // electronic switches closed
   output logic [6:0] V_SET, // terminal voltage setpoint, percent
   output logic STARTING, // start ramp active
   output logic RUNDOWN, // run-down active
   output logic ILIM_ACT, // current limiting active
   output logic LOCKOUT_ACT, // lock-out time active
   output logic BRAKE_ON // brake output energised
);
   import msc_pkg::*;

   function automatic logic [15:0] sat16(input logic [15:0] x, input logic [15:0] lo,
      input logic [15:0] hi);
      sat16 = (x < lo) ? lo : ((x > hi) ? hi : x);
   endfunction : sat16

   logic [11:0] ie_q;
   logic [6:0] vstart_q, vstop_q;
   logic [IMG_W-1:0] sub_q, eff_q;
   logic rej_q, ms_tick, fs, req_f, req_r, on_cmd, over, lim_mode;
   logic [15:0] tick_q, dcnt_q, acc_q, hcnt_q, lock_ms, up_ms, dn_ms, up_span, dn_span;
   logic [7:0] ilim_q;
   logic [11:0] iee_q;
   dir_state_e st_q;
   volt_state_e vm_q;
   logic rev_q, son_q, lock_q, strt_q, rdn_q, ilim_act_q, abandon_q, brk_q;
   logic [6:0] v_q;
   logic asym_en_q, asym_q, ovl_q, eprev_q, gf_q, gw_q, diag_q;

   // Parameter set; a bad substitute image keeps the previous one.
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         ie_q <= IE_MAX;
         sub_q <= SUBST_RST;
         vstart_q <= V_DEF_PCT;
         vstop_q <= V_DEF_PCT;
         rej_q <= 1'b0;
      end
      else if (CFG_LOAD)
      begin
         ie_q <= IE_SET;
         if (!(SUBST_IMG[IMG_FWD] && SUBST_IMG[IMG_REV]))
            sub_q <= SUBST_IMG;
         rej_q <= (SUBST_IMG[IMG_FWD] && SUBST_IMG[IMG_REV])
            || (STARTUP_MODE == SM_DIRECT && TRIP_CLASS != CLASS_5
            && TRIP_CLASS != CLASS_10);
         vstart_q <= 7'(sat16(16'(V_START_STEP) * V_STEP_PCT, V_MIN_PCT,
            16'(V_FULL_PCT)));
         vstop_q <= 7'(sat16(16'(V_STOP_STEP) * V_STEP_PCT, V_MIN_PCT, VSTOP_MAX_PCT));
      end
   end

   // Direct starting derates the part, so the current ceiling follows the mode.
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         iee_q <= IE_MAX;
         ilim_q <= 8'(ILIM_MAX);
      end
      else
      begin
         iee_q <= 12'(sat16(16'(ie_q), 16'(IE_MIN), 16'((STARTUP_MODE == SM_DIRECT)
            ? IE_DIRECT : IE_MAX_P)));
         ilim_q <= 8'(sat16(16'(ILIM_SET), ILIM_MIN,
            (iee_q > IE_DIRECT) ? ILIM_MAX_HI : ILIM_MAX));
      end
   end

   // Master STOP only counts in automatic mode; a bus failure always does.
   assign fs = BUS_FAIL || (AUTO_MODE && MASTER_STOP);
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         eff_q <= SUBST_RST;
      else if (!fs)
         eff_q <= CMD_IMG;
      else if (STOP_SUBST)
         eff_q <= sub_q;
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         tick_q <= 16'h0000;
      else if (tick_q == 16'(MS_CYC_P - 1))
         tick_q <= 16'h0000;
      else
         tick_q <= tick_q + 16'h0001;
   end
   assign ms_tick = (tick_q == 16'(MS_CYC_P - 1));

   // A command for both directions counts as no command at all.
   assign req_f = eff_q[IMG_FWD] && !eff_q[IMG_REV];
   assign req_r = eff_q[IMG_REV] && !eff_q[IMG_FWD];
   assign on_cmd = rev_q ? req_r : req_f;
   assign lock_ms = (LOCKOUT_S == 6'h00) ? LOCK_ZERO_MS
      : sat16(16'(LOCKOUT_S), 16'h0000, LOCK_MAX_S) * 16'(MS_PER_S);

   // The contactor only moves in idle, where the switches are open.
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         st_q <= D_IDLE;
         rev_q <= 1'b0;
         dcnt_q <= 16'h0000;
      end
      else
      begin
         case (st_q)
            D_IDLE:
               if (req_f || req_r)
               begin
                  rev_q <= req_r;
                  dcnt_q <= 16'h0000;
                  st_q <= (req_r != rev_q) ? D_SETTLE : D_RUN;
               end
            D_SETTLE:
               if (dcnt_q >= SETTLE_MS)
                  st_q <= D_RUN;
               else if (ms_tick)
                  dcnt_q <= dcnt_q + 16'h0001;
            D_RUN:
               if (!on_cmd && vm_q == V_OFF)
               begin
                  st_q <= D_LOCK;
                  dcnt_q <= 16'h0000;
               end
            D_LOCK:
               if (on_cmd)
                  st_q <= D_RUN; // same direction aborts lock-out
               else if (dcnt_q >= lock_ms)
                  st_q <= D_IDLE;
               else if (ms_tick)
                  dcnt_q <= dcnt_q + 16'h0001;
            default:
               st_q <= D_IDLE;
         endcase
      end
   end

   assign up_ms = (START_T == 7'h00) ? START_MIN_MS
      : sat16(16'(START_T), 16'h0000, T_MAX_Q) * T_Q_MS;
   assign dn_ms = sat16(16'(RUNDOWN_T), 16'h0000, T_MAX_Q) * T_Q_MS;
   assign up_span = 16'(V_FULL_PCT - vstart_q);
   assign dn_span = 16'(V_FULL_PCT - vstop_q);
   assign over = CUR_RATIO > ilim_q;
   assign lim_mode = STARTUP_MODE == SM_ILIM || STARTUP_MODE == SM_RAMP_ILIM;

   // Each tick adds the span to an accumulator and steps 1 % per full duration,
   // which gives a linear ramp without a divider.
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         vm_q <= V_OFF;
         v_q <= 7'h00;
         acc_q <= 16'h0000;
         abandon_q <= 1'b0;
         ilim_act_q <= 1'b0;
      end
      else
      begin
         case (vm_q)
            V_OFF:
               if (st_q == D_RUN && on_cmd)
               begin
                  acc_q <= 16'h0000;
                  abandon_q <= 1'b0;
                  if (STARTUP_MODE == SM_DIRECT)
                  begin
                     vm_q <= V_ON;
                     v_q <= V_FULL_PCT;
                  end
                  else
                  begin
                     vm_q <= V_UP;
                     v_q <= vstart_q;
                  end
               end
            V_UP, V_ON:
               if (!on_cmd)
               begin
                  ilim_act_q <= 1'b0;
                  acc_q <= 16'h0000;
                  // At or below the stop voltage there is nothing to run down, so switch off.
                  if (!RUNDOWN_RAMP || RUNDOWN_T == 7'h00 || v_q <= vstop_q)
                  begin
                     vm_q <= V_OFF;
                     v_q <= 7'h00;
                  end
                  else
                     vm_q <= V_DOWN;
               end
               else if (vm_q == V_UP && v_q >= V_FULL_PCT)
               begin
                  vm_q <= V_ON;
                  ilim_act_q <= 1'b0;
               end
               else if (vm_q == V_UP && ms_tick)
               begin
                  ilim_act_q <= lim_mode && over;
                  if (lim_mode && over)
                     abandon_q <= abandon_q || STARTUP_MODE == SM_RAMP_ILIM;
                  else if (abandon_q)
                     v_q <= v_q + 7'h01;
                  else if (acc_q + up_span >= up_ms)
                  begin
                     v_q <= v_q + 7'h01;
                     acc_q <= acc_q + up_span - up_ms;
                  end
                  else
                     acc_q <= acc_q + up_span;
               end
            V_DOWN:
               if (REGEN || v_q <= vstop_q)
               begin
                  vm_q <= V_OFF;
                  v_q <= 7'h00;
               end
               else if (ms_tick)
               begin
                  if (acc_q + dn_span >= dn_ms)
                  begin
                     v_q <= v_q - 7'h01;
                     acc_q <= acc_q + dn_span - dn_ms;
                  end
                  else
                     acc_q <= acc_q + dn_span;
               end
            default:
               vm_q <= V_OFF;
         endcase
      end
   end

   // With no holding time the brake follows the motor, including an aborted run-down.
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         brk_q <= 1'b0;
         hcnt_q <= 16'h0000;
      end
      else if (eff_q[IMG_BRAKE])
      begin
         brk_q <= 1'b1;
         hcnt_q <= 16'h0000;
      end
      else if (brk_q)
      begin
         if (BRAKE_HOLD_MS == 16'h0000)
         begin
            if (vm_q == V_OFF)
               brk_q <= 1'b0;
         end
         else if (hcnt_q >= BRAKE_HOLD_MS)
            brk_q <= 1'b0;
         else if (ms_tick)
            hcnt_q <= hcnt_q + 16'h0001;
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         son_q <= 1'b0;
         lock_q <= 1'b0;
         strt_q <= 1'b0;
         rdn_q <= 1'b0;
      end
      else
      begin
         son_q <= vm_q != V_OFF;
         lock_q <= st_q == D_LOCK;
         strt_q <= vm_q == V_UP;
         rdn_q <= vm_q == V_DOWN;
      end
   end

   // An overload event in the same cycle as a clear still leaves the flag set.
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         asym_en_q <= 1'b1;
         asym_q <= 1'b0;
         ovl_q <= 1'b0;
         eprev_q <= 1'b1;
         gf_q <= 1'b0;
         gw_q <= 1'b0;
         diag_q <= 1'b0;
      end
      else
      begin
         asym_en_q <= !LOAD_1PH;
         asym_q <= !LOAD_1PH && ASYM_RAW;
         eprev_q <= ELEC_SUPPLY_OK;
         if (OVERLOAD_EV)
            ovl_q <= 1'b1;
         else if (eff_q[IMG_TRIP_RST] || (eprev_q && !ELEC_SUPPLY_OK && !VFAIL_RETAIN))
            ovl_q <= 1'b0;
         gf_q <= asym_q || (!SW_SUPPLY_OK && (SUPPLY_RESP == SR_FAULT
            || (SUPPLY_RESP == SR_FAULT_ON && (req_f || req_r))));
         gw_q <= !SW_SUPPLY_OK && SUPPLY_RESP == SR_WARN;
         diag_q <= GRP_DIAG_EN && (gf_q || gw_q || ovl_q);
      end
   end

   assign IE_EFF = iee_q;
   assign ILIM_EFF = ilim_q;
   assign PARAM_REJ = rej_q;
   assign EFF_IMG = eff_q;
   assign ASYM_EN = asym_en_q;
   assign ASYM_FLT = asym_q;
   assign OVL_PEND = ovl_q;
   assign GRP_FAULT = gf_q;
   assign GRP_WARN = gw_q;
   assign DIAG_TX = diag_q;
   assign CONT_REV = rev_q;
   assign SW_ON = son_q;
   assign V_SET = v_q;
   assign STARTING = strt_q;
   assign RUNDOWN = rdn_q;
   assign ILIM_ACT = ilim_act_q;
   assign LOCKOUT_ACT = lock_q;
   assign BRAKE_ON = brk_q;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);

   a_ie_range: assert property (IE_EFF >= IE_MIN && IE_EFF <= IE_MAX_P)
      else $error("rated current out of range");
   a_direct_derate: assert property ((STARTUP_MODE == SM_DIRECT) |=> (IE_EFF <= IE_DIRECT))
      else $error("direct start not derated");
   a_asym_off: assert property (LOAD_1PH |=> !ASYM_EN && !ASYM_FLT)
      else $error("asymmetry active on single-phase load");
   a_subst_used: assert property (BUS_FAIL && STOP_SUBST |=> EFF_IMG == $past(sub_q))
      else $error("substitute image not applied");
   a_subst_reject: assert property (CFG_LOAD && SUBST_IMG[IMG_FWD] && SUBST_IMG[IMG_REV]
      |=> PARAM_REJ && $stable(sub_q))
      else $error("conflicting substitute image taken");
   a_diag_block: assert property (!GRP_DIAG_EN |=> !DIAG_TX)
      else $error("diagnostics sent while blocked");
   a_dir_stable: assert property (vm_q != V_OFF |-> $stable(CONT_REV))
      else $error("contactor moved while switches closed");
   a_settle_open: assert property (st_q == D_SETTLE |-> vm_q == V_OFF ##1 !SW_ON)
      else $error("switches closed during contactor settle");
   a_lock_hold: assert property (st_q == D_LOCK |=> LOCKOUT_ACT && CONT_REV == $past(CONT_REV))
      else $error("direction changed during lock-out");
   a_lock_zero: assert property (st_q == D_LOCK && LOCKOUT_S == 6'h00
      |-> dcnt_q <= LOCK_ZERO_MS)
      else $error("zero lock-out not 150 ms");
   a_regen_abort: assert property (vm_q == V_DOWN && REGEN |=> vm_q == V_OFF ##1 !SW_ON)
      else $error("regenerative run-down not aborted");
   a_brake_zero: assert property (BRAKE_HOLD_MS == 16'h0000 && !eff_q[IMG_BRAKE]
      && vm_q == V_OFF |=> !BRAKE_ON)
      else $error("brake kept after motor off");
   a_down_floor: assert property (vm_q == V_DOWN |-> v_q >= vstop_q && v_q <= V_FULL_PCT)
      else $error("run-down below stopping voltage");
endmodule : motor_starter_control_sequencer
`default_nettype wire

// >>> tb/bus_master_model.sv
// Purpose: Behavioural fieldbus master that drives the starter's live command image.
// Assumes: The bench hands its requests over on the rising clock edge.
// Notes: A failed bus shows an image that inverts every cycle, so it matches the last one only on alternate cycles.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
   input wire logic clk, // control clock
   input wire logic reset_n, // asynchronous reset, active low
   input wire logic [8:0] req_img, // image requested by the bench
   input wire logic req_stop, // enter STOP
   input wire logic req_fail, // break the bus
   output logic [8:0] cmd_img, // image sent to the starter
   output logic master_stop, // master in STOP
   output logic bus_fail // bus failure
);
   // While the bus is broken the image toggles, so a device that still trusts it is caught.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cmd_img <= 9'h000;
         master_stop <= 1'b0;
         bus_fail <= 1'b0;
      end
      else
      begin
         cmd_img <= req_fail ? ~cmd_img : req_img;
         master_stop <= req_stop;
         bus_fail <= req_fail;
      end
   end
endmodule : bus_master_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Self-checking bench of the motor starter control sequencer.
// Assumes: The millisecond tick is shortened to 4 clock cycles.
// Notes: Inputs change on the rising edge by non-blocking assignment.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import msc_pkg::*;
   localparam int TICK = 4;
   typedef struct {logic [11:0] ie; startup_e m; logic [3:0] c; logic [7:0] il;
      logic [11:0] xie; logic xr; logic [7:0] xil;} row_s;
   row_s rows [5] = '{'{12'h4b0, SM_RAMP, 4'hf, 8'hc8, 12'h4b0, 1'b0, 8'hb0},
      '{12'h4b0, SM_DIRECT, 4'ha, 8'hc8, 12'h384, 1'b0, 8'hc0},
      '{12'h00f, SM_RAMP, 4'ha, 8'h0a, 12'h00f, 1'b0, 8'h28},
      '{12'h1f4, SM_DIRECT, 4'h7, 8'h64, 12'h1f4, 1'b1, 8'h64},
      '{12'h385, SM_RAMP, 4'h5, 8'hc0, 12'h385, 1'b0, 8'hb0}};
   logic clk = 0, rst_n = 0, cfg = 0, rdr = 0, ld1 = 0, vret = 1, ssub = 1, diag = 0, auto = 0;
   logic regen = 0, asr = 0, ovl = 0, eok = 1, sok = 1, rstop = 0, rfail = 0;
   logic [11:0] ie = 12'h4b0;
   startup_e mode = SM_RAMP;
   supply_resp_e resp = SR_FAULT;
   logic [3:0] cls = 4'ha;
   logic [4:0] vst = 5'h08, vsp = 5'h08;
   logic [6:0] st = 7'h00, rt = 7'h00, vset;
   logic [7:0] il = 8'hc0, cur = 8'h00, il_eff;
   logic [5:0] lk = 6'h00;
   logic [15:0] bh = 16'h0000;
   logic [8:0] sub = 9'h000, rimg = 9'h000, cimg, eff;
   logic [11:0] ie_eff;
   logic mst, bfl, rej, asen, asf, ovp, gf, gw, dtx, crev, swon, sting, rdn, ila, lka, brk;
   int n_mismatch = 0, tests_run = 0, cnt;
   always #12.5 clk = ~clk;
   bus_master_model bus_master_model_inst (.clk(clk), .reset_n(rst_n), .req_img(rimg),
      .req_stop(rstop), .req_fail(rfail), .cmd_img(cimg), .master_stop(mst), .bus_fail(bfl));
   motor_starter_control_sequencer #(.MS_CYC_P(TICK)) motor_starter_control_sequencer_inst (
      .CLK(clk), .RESET_N(rst_n), .CFG_LOAD(cfg), .IE_SET(ie), .STARTUP_MODE(mode),
      .TRIP_CLASS(cls), .V_START_STEP(vst), .V_STOP_STEP(vsp), .START_T(st), .RUNDOWN_T(rt),
      .RUNDOWN_RAMP(rdr), .ILIM_SET(il), .LOCKOUT_S(lk), .BRAKE_HOLD_MS(bh), .LOAD_1PH(ld1),
      .VFAIL_RETAIN(vret), .SUPPLY_RESP(resp), .STOP_SUBST(ssub), .SUBST_IMG(sub),
      .GRP_DIAG_EN(diag), .AUTO_MODE(auto), .MASTER_STOP(mst), .BUS_FAIL(bfl), .CMD_IMG(cimg),
      .CUR_RATIO(cur), .REGEN(regen), .ASYM_RAW(asr), .OVERLOAD_EV(ovl), .ELEC_SUPPLY_OK(eok),
      .SW_SUPPLY_OK(sok), .IE_EFF(ie_eff), .ILIM_EFF(il_eff), .PARAM_REJ(rej), .EFF_IMG(eff),
      .ASYM_EN(asen), .ASYM_FLT(asf), .OVL_PEND(ovp), .GRP_FAULT(gf), .GRP_WARN(gw),
      .DIAG_TX(dtx), .CONT_REV(crev), .SW_ON(swon), .V_SET(vset), .STARTING(sting),
      .RUNDOWN(rdn), .ILIM_ACT(ila), .LOCKOUT_ACT(lka), .BRAKE_ON(brk));
   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1)
      begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask : chk
   task automatic stop_test;
      if (n_mismatch == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle
   // Bounded wait; the cycles spent are left in cnt for timing checks.
   task automatic wait_for(ref logic s, input logic v, input int lim);
      cnt = 0;
      while (s !== v && cnt < lim)
      begin
         @(posedge clk);
         #1;
         cnt++;
      end
   endtask : wait_for
   task automatic load_cfg;
      @(posedge clk);
      cfg <= 1'b1;
      @(posedge clk);
      cfg <= 1'b0;
   endtask : load_cfg
   initial
   begin
      settle(2);
      chk(ie_eff === IE_MAX && il_eff === 8'hc0 && asen === 1'b1 && swon === 1'b0, "reset");
      @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i])
      begin
         @(posedge clk);
         ie <= rows[i].ie;
         mode <= rows[i].m;
         cls <= rows[i].c;
         il <= rows[i].il;
         load_cfg();
         settle(4);
         chk(ie_eff === rows[i].xie && rej === rows[i].xr && il_eff === rows[i].xil, "config");
      end
      @(posedge clk);
      ld1 <= 1'b1;
      settle(3);
      chk(asen === 1'b0, "asymmetry still enabled");
      @(posedge clk);
      ld1 <= 1'b0;
      sok <= 1'b0;
      settle(3);
      chk(gf === 1'b1 && dtx === 1'b0, "blocked fault");
      @(posedge clk);
      diag <= 1'b1;
      settle(3);
      chk(dtx === 1'b1, "diagnostics not sent");
      @(posedge clk);
      resp <= SR_WARN;
      settle(3);
      chk(gw === 1'b1 && gf === 1'b0, "supply warning");
      @(posedge clk);
      sok <= 1'b1;
      resp <= SR_FAULT;
      sub <= 9'h004;
      load_cfg();
      rfail <= 1'b1;
      settle(4);
      chk(eff === 9'h004 && rej === 1'b0, "substitute image");
      @(posedge clk);
      sub <= 9'h003;
      load_cfg();
      settle(3);
      chk(rej === 1'b1 && eff === 9'h004, "both directions taken");
      @(posedge clk);
      rfail <= 1'b0;
      rimg <= 9'h040;
      settle(4);
      chk(eff === 9'h040, "live image");
      @(posedge clk);
      auto <= 1'b1;
      rstop <= 1'b1;
      ssub <= 1'b0;
      settle(3);
      @(posedge clk);
      rimg <= 9'h080;
      settle(3);
      chk(eff === 9'h040, "hold on STOP");
      @(posedge clk);
      auto <= 1'b0;
      rstop <= 1'b0;
      rimg <= 9'h001;
      wait_for(swon, 1'b1, 30);
      chk(swon === 1'b1 && crev === 1'b0, "forward start");
      chk(sting === 1'b1 && vset === 7'h28, "start ramp");
      @(posedge clk);
      rimg <= 9'h000;
      wait_for(lka, 1'b1, 20);
      chk(swon === 1'b0 && lka === 1'b1, "stop without load");
      cnt = 0;
      while (lka === 1'b1 && cnt < 700)
      begin
         @(posedge clk);
         if (cnt == 5)
            rimg <= 9'h002;
         #1;
         cnt++;
         if (lka === 1'b1 && (swon !== 1'b0 || crev !== 1'b0))
            chk(1'b0, "reverse during lock-out");
      end
      chk(cnt >= 595 && cnt <= 605, "lock-out length");
      wait_for(swon, 1'b1, 400);
      chk(crev === 1'b1 && cnt >= 80 * TICK && cnt <= 80 * TICK + 15, "reverse settle");
      @(posedge clk);
      rimg <= 9'h000;
      wait_for(swon, 1'b0, 6);
      chk(swon === 1'b0, "reverse stop");
      @(posedge clk);
      mode <= SM_DIRECT;
      rdr <= 1'b1;
      rt <= 7'h04;
      rimg <= 9'h006;
      wait_for(swon, 1'b1, 20);
      chk(vset === 7'h64 && brk === 1'b1 && sting === 1'b0, "direct start");
      @(posedge clk);
      rimg <= 9'h000;
      wait_for(rdn, 1'b1, 10);
      chk(rdn === 1'b1 && swon === 1'b1, "run-down ramp");
      @(posedge clk);
      regen <= 1'b1;
      settle(1);
      chk(swon === 1'b1 && brk === 1'b1, "early motor off");
      settle(1);
      chk(swon === 1'b0 && brk === 1'b0 && vset === 7'h00, "regen abort");
      @(posedge clk);
      regen <= 1'b0;
      rdr <= 1'b0;
      bh <= 16'h000a;
      rimg <= 9'h006;
      wait_for(swon, 1'b1, 20);
      @(posedge clk);
      rimg <= 9'h000;
      wait_for(brk, 1'b0, 60);
      chk(swon === 1'b0 && cnt >= 10 * TICK && cnt <= 10 * TICK + 8, "brake holding");
      @(posedge clk);
      ovl <= 1'b1;
      @(posedge clk);
      ovl <= 1'b0;
      eok <= 1'b0;
      settle(3);
      chk(ovp === 1'b1 && dtx === 1'b1, "overload not retained");
      @(posedge clk);
      eok <= 1'b1;
      vret <= 1'b0;
      @(posedge clk);
      eok <= 1'b0;
      settle(3);
      chk(ovp === 1'b0, "overload not cleared");
      stop_test();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      stop_test();
   end
endmodule : testbench
`default_nettype wire
